// [rtl/acr_control.sv]
// acr_control: register file and sequencing for a 12-bit converter.
// assumes an APB master on pclk and a converter core whose sample is
// already stable on sample_data when a conversion ends.
// low_voltage_monitor and sample_data come from logic on pclk, so no
// synchroniser sits in front of them; clk_en low freezes every register.
`timescale 1ns/100ps
`default_nettype none
module acr_control (
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converter core side
   input wire logic [11:0] sample_data,
   input wire logic low_voltage_monitor,
   output acr_pkg::acr_route_t route,
   output logic converter_reset,
   output logic conv_tick,
   output logic conv_done,
   // pin side
   output logic [9:0] pullup_disable,
   output logic ref_pin_shared_disable
);
   // register state
   logic [7:0] start_chan_reg; // start, power, align, channel (busy kept apart)
   logic [7:0] ref_clock_reg; // bandgap select/enable, reference, divider
   logic [9:0] pin_en_reg; // analog pin enables
   logic busy_reg; // conversion busy flag
   logic [11:0] result_reg; // last completed conversion
   logic converting_reg; // conversion counter running
   logic [4:0] tick_cnt_reg; // converter ticks in this conversion
   logic [5:0] div_cnt_reg; // system clocks toward next tick
   logic done_reg; // one-cycle completion pulse
   logic [5:0] div_limit; // divide ratio minus one
   logic wr_en; // apb write in access phase
   logic start_fall; // start written from high to low
   logic start_rise; // start written from low to high
   logic start_wr; // write to the start/channel register

   // divider ratio decode, reused by the divider counter and the tick output
   function automatic logic [5:0] div_ratio_m1(input logic [2:0] code);
      // undefined code treated as slowest ratio to stay safe
      if (code == acr_pkg::DIV_UNDEFINED)
         div_ratio_m1 = 6'h3f;
      else
         div_ratio_m1 = 6'((7'h01 << code) - 7'h01);
   endfunction

   // channel decode for the mux
   // codes nine to fifteen fold onto the top input
   function automatic logic [3:0] chan_map(input logic [3:0] code);
      if (code > acr_pkg::LAST_DIRECT_CHAN)
         chan_map = acr_pkg::TOP_CHAN;
      else
         chan_map = code;
   endfunction

   // bus decode; writes and the read capture both wait for clk_en
   assign pready = 1'b1; // zero wait states
   assign wr_en = psel && penable && pwrite && clk_en;
   assign start_wr = wr_en && (paddr == acr_pkg::OFF_START_CHAN);
   assign start_rise = start_wr && pwdata[acr_pkg::START_BIT]
      && !start_chan_reg[acr_pkg::START_BIT];
   assign start_fall = start_wr && !pwdata[acr_pkg::START_BIT]
      && start_chan_reg[acr_pkg::START_BIT];
   assign div_limit = div_ratio_m1(ref_clock_reg[2:0]);

   // unmapped address answers with an error
   // decoded from the bus alone, so the error answer needs no clk_en
   always_comb
   begin
      pslverr = 1'b0;
      if (psel && penable)
      begin
         if (paddr == acr_pkg::OFF_RESULT_LOW) pslverr = 1'b0;
         else if (paddr == acr_pkg::OFF_RESULT_HIGH) pslverr = 1'b0;
         else if (paddr == acr_pkg::OFF_START_CHAN) pslverr = 1'b0;
         else if (paddr == acr_pkg::OFF_REF_CLOCK) pslverr = 1'b0;
         else if (paddr == acr_pkg::OFF_PIN_EN_LOW) pslverr = 1'b0;
         else if (paddr == acr_pkg::OFF_PIN_EN_HIGH) pslverr = 1'b0;
         else pslverr = 1'b1;
      end
   end

   // start/channel control; busy bit is not stored here so writes miss it
   // the busy position is written as zero and read back from busy_reg
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         start_chan_reg <= acr_pkg::START_CHAN_RESET;
      else if (start_wr)
         start_chan_reg <= {pwdata[7], 1'b0, pwdata[5:0]};
   end

   // reference/clock control, holes masked to zero
   // bits five and three have no storage; the mask keeps them zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ref_clock_reg <= acr_pkg::REF_CLOCK_RESET;
      else if (wr_en && paddr == acr_pkg::OFF_REF_CLOCK)
         ref_clock_reg <= pwdata[7:0] & acr_pkg::REF_CLOCK_MASK;
   end

   // analog pin enables
   // the high register holds only two enables; its upper bits drop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pin_en_reg <= acr_pkg::PIN_EN_RESET;
      else if (wr_en && paddr == acr_pkg::OFF_PIN_EN_LOW)
         pin_en_reg[7:0] <= pwdata[7:0];
      else if (wr_en && paddr == acr_pkg::OFF_PIN_EN_HIGH)
         pin_en_reg[9:8] <= pwdata[1:0];
   end

   // converter clock divider; held cleared while converter idle
   // restarting with each launch puts the first tick one full converter
   // period after start falls, whatever the counter held before
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         div_cnt_reg <= 6'h00;
      else if (clk_en)
      begin
         if (!converting_reg || div_cnt_reg >= div_limit)
            div_cnt_reg <= 6'h00;
         else
            div_cnt_reg <= div_cnt_reg + 6'h01;
      end
   end

   // >= rather than == so a divider rewrite mid-conversion cannot overrun
   assign conv_tick = converting_reg && (div_cnt_reg >= div_limit);

   // conversion sequencer: start fall launches, start high holds reset
   // the launch looks at the stored power-down bit, not the one written
   // with the falling start, so software powers up before it starts;
   // a run lasts CONV_TICKS converter clocks and then stops by itself
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         converting_reg <= 1'b0;
         tick_cnt_reg <= 5'h00;
      end
      else if (clk_en)
      begin
         if (start_chan_reg[acr_pkg::START_BIT] && !start_fall)
         begin
            converting_reg <= 1'b0;
            tick_cnt_reg <= 5'h00;
         end
         else if (start_fall && !start_chan_reg[acr_pkg::POWER_DOWN_BIT])
         begin
            converting_reg <= 1'b1;
            tick_cnt_reg <= 5'h00;
         end
         else if (conv_tick)
         begin
            // a converter powered off before start falls never launches; busy stays high
            if (tick_cnt_reg == acr_pkg::CONV_TICKS - 5'h01)
               converting_reg <= 1'b0;
            tick_cnt_reg <= tick_cnt_reg + 5'h01;
         end
      end
   end

   // completion pulse toward the interrupt controller
   // busy falls on the same edge, so polling and the request agree
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         done_reg <= 1'b0;
      else if (clk_en)
         done_reg <= conv_tick && tick_cnt_reg == acr_pkg::CONV_TICKS - 5'h01;
   end

   assign conv_done = done_reg;

   // busy flag: set by start rise, cleared at completion
   // set wins, so a start landing on the completion edge keeps busy high
   // rather than letting software see a finish for the aborted run
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         busy_reg <= 1'b1;
      else if (clk_en)
      begin
         if (start_rise || start_chan_reg[acr_pkg::START_BIT])
            busy_reg <= 1'b1;
         else if (conv_tick && tick_cnt_reg == acr_pkg::CONV_TICKS - 5'h01)
            busy_reg <= 1'b0;
      end
   end

   // result latched whole at completion
   // a run cut short by a new start never gets here, so the last good
   // result stays readable until the next conversion ends
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         result_reg <= 12'h000;
      else if (clk_en && conv_tick && tick_cnt_reg == acr_pkg::CONV_TICKS - 5'h01)
         result_reg <= sample_data;
   end

   // converter held in reset while start high; power-down goes via route
   assign converter_reset = start_chan_reg[acr_pkg::START_BIT];

   // routing outputs to the analog side
   // purely combinational so the analog mux follows a write at once
   always_comb
   begin
      route.bandgap_route = ref_clock_reg[acr_pkg::BG_SELECT_BIT];
      route.channel = chan_map(start_chan_reg[3:0]);
      route.ext_ref = ref_clock_reg[acr_pkg::REF_SELECT_BIT];
      route.bandgap_on = ref_clock_reg[acr_pkg::BG_ENABLE_BIT]
         || low_voltage_monitor;
      route.powered = !start_chan_reg[acr_pkg::POWER_DOWN_BIT];
      route.analog_pin_enables = pin_en_reg;
   end

   // pin side follows the enables with no extra delay
   assign pullup_disable = pin_en_reg;
   assign ref_pin_shared_disable = ref_clock_reg[acr_pkg::REF_SELECT_BIT];

   // read mux, registered for stable data
   // captured at the setup edge so the access phase needs no wait state;
   // prdata then stands unchanged until the next read setup
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (clk_en && psel && !penable && !pwrite)
      begin
         if (paddr == acr_pkg::OFF_RESULT_LOW)
            prdata <= start_chan_reg[acr_pkg::ALIGN_BIT] ? {24'h0, result_reg[7:0]}
               : {24'h0, result_reg[3:0], 4'h0};
         else if (paddr == acr_pkg::OFF_RESULT_HIGH)
            prdata <= start_chan_reg[acr_pkg::ALIGN_BIT] ? {28'h0, result_reg[11:8]}
               : {24'h0, result_reg[11:4]};
         else if (paddr == acr_pkg::OFF_START_CHAN)
            prdata <= {24'h0, start_chan_reg[7], busy_reg, start_chan_reg[5:0]};
         else if (paddr == acr_pkg::OFF_REF_CLOCK)
            prdata <= {24'h0, ref_clock_reg};
         else if (paddr == acr_pkg::OFF_PIN_EN_LOW)
            prdata <= {24'h0, pin_en_reg[7:0]};
         else if (paddr == acr_pkg::OFF_PIN_EN_HIGH)
            prdata <= {30'h0, pin_en_reg[9:8]};
         else
            prdata <= 32'h0000_0000;
      end
   end

   // checks
   // all of them rest while reset is low; $past and $stable then start
   // from reset values at the first edge after release
   chk_busy_on_start: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && start_rise) |=> busy_reg)
      else $error("busy not set after start rise");
   chk_conv_launch: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && start_fall && !start_chan_reg[acr_pkg::POWER_DOWN_BIT]) |=> converting_reg)
      else $error("conversion not launched on start fall");
   chk_done_clears: assert property (@(posedge pclk) disable iff (!presetn)
      (done_reg && !start_chan_reg[acr_pkg::START_BIT]) |-> !busy_reg && !converting_reg)
      else $error("busy still high at completion");
   chk_result_stable: assert property (@(posedge pclk) disable iff (!presetn)
      (converting_reg && !done_reg) |=> ($stable(result_reg) || done_reg))
      else $error("result changed mid conversion");
   chk_held_reset: assert property (@(posedge pclk) disable iff (!presetn)
      (start_chan_reg[acr_pkg::START_BIT] && clk_en && !start_fall) |=> !converting_reg)
      else $error("converter ran while start high");
   chk_chan_top: assert property (@(posedge pclk) disable iff (!presetn)
      start_chan_reg[3:0] > acr_pkg::LAST_DIRECT_CHAN |-> route.channel == acr_pkg::TOP_CHAN)
      else $error("high code did not select top channel");
   chk_ref_holes: assert property (@(posedge pclk) disable iff (!presetn)
      ref_clock_reg[5] == 1'b0 && ref_clock_reg[3] == 1'b0)
      else $error("unimplemented bits set");
   chk_bandgap_off: assert property (@(posedge pclk) disable iff (!presetn)
      (!ref_clock_reg[acr_pkg::BG_ENABLE_BIT] && !low_voltage_monitor) |-> !route.bandgap_on)
      else $error("bandgap left on");

   // sequencing and read path checks
   // completion pulse lasts one cycle unless the clock enable holds it
   chk_done_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      (done_reg && clk_en) |=> !done_reg)
      else $error("completion pulse longer than one cycle");
   // a running conversion always shows busy
   chk_busy_in_conv: assert property (@(posedge pclk) disable iff (!presetn)
      converting_reg |-> busy_reg)
      else $error("busy low while converting");
   // start left high keeps busy set and the core in reset
   chk_start_busy: assert property (@(posedge pclk) disable iff (!presetn)
      start_chan_reg[acr_pkg::START_BIT] |-> busy_reg && converter_reset)
      else $error("start high without busy or core reset");
   // a powered-down converter ignores the start sequence
   chk_pd_no_launch: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && start_fall && start_chan_reg[acr_pkg::POWER_DOWN_BIT]) |=> !converting_reg)
      else $error("conversion launched while powered down");
   // read data holes of the result low byte in the left-aligned layout
   chk_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && $past(clk_en) && paddr == acr_pkg::OFF_RESULT_LOW
         && !start_chan_reg[acr_pkg::ALIGN_BIT])
         |-> (prdata[31:8] == 24'h0 && prdata[3:0] == 4'h0))
      else $error("unused result bits not zero");

   // cover points for the main scenarios
   cov_conv_done: cover property (@(posedge pclk) done_reg);
   cov_start_rise: cover property (@(posedge pclk) start_rise);
   cov_align_read: cover property (@(posedge pclk) start_chan_reg[acr_pkg::ALIGN_BIT] && done_reg);
   cov_bandgap_conv: cover property (@(posedge pclk) route.bandgap_route && done_reg);
   cov_slow_divider: cover property (@(posedge pclk) ref_clock_reg[2:0] == 3'h6 && done_reg);
endmodule // acr_control
`default_nettype wire

// [rtl/acr_pkg.sv]
// acr_pkg: register map, field positions, reset values and timing counts
// for the converter control block; shared by the block and its bench.
package acr_pkg;
   // register offsets (byte addresses, one aligned 32-bit word each)
   localparam logic [7:0] OFF_RESULT_LOW = 8'h00;
   localparam logic [7:0] OFF_RESULT_HIGH = 8'h04;
   localparam logic [7:0] OFF_START_CHAN = 8'h08;
   localparam logic [7:0] OFF_REF_CLOCK = 8'h0c;
   localparam logic [7:0] OFF_PIN_EN_LOW = 8'h10;
   localparam logic [7:0] OFF_PIN_EN_HIGH = 8'h14;
   // start/channel control field positions
   localparam int START_BIT = 7;
   localparam int BUSY_BIT = 6;
   localparam int POWER_DOWN_BIT = 5;
   localparam int ALIGN_BIT = 4;
   // reference/clock control field positions
   localparam int BG_SELECT_BIT = 7;
   localparam int BG_ENABLE_BIT = 6;
   localparam int REF_SELECT_BIT = 4;
   // reset values
   localparam logic [7:0] START_CHAN_RESET = 8'h60;
   localparam logic [7:0] REF_CLOCK_RESET = 8'h00;
   localparam logic [7:0] REF_CLOCK_MASK = 8'hd7;
   localparam logic [9:0] PIN_EN_RESET = 10'h000;
   // channel routing
   localparam logic [3:0] LAST_DIRECT_CHAN = 4'h8;
   localparam logic [3:0] TOP_CHAN = 4'h9;
   // conversion length in converter clock ticks
   localparam logic [4:0] CONV_TICKS = 5'h10;
   localparam logic [2:0] DIV_UNDEFINED = 3'h7;
   // routing and pin control carried as one bundle
   typedef struct packed {
      logic bandgap_route;
      logic [3:0] channel;
      logic ext_ref;
      logic bandgap_on;
      logic powered;
      logic [9:0] analog_pin_enables;
   } acr_route_t;
endpackage

// [sim/acr_analog_model.sv]
// acr_analog_model: analog pins and bandgap seen by the converter core.
// assumes the route bundle of the control block; one level per input.
`timescale 1ns/100ps
`default_nettype none
module acr_analog_model #(
   parameter logic [11:0] BG_LEVEL = 12'h5a3
) (
   // routing from the control block
   input wire acr_pkg::acr_route_t route,
   // sample handed to the core
   output logic [11:0] sample_data
);
   // each pin gets a distinct level so a wrong route shows at once
   always_comb
   begin
      if (!route.powered)
         sample_data = 12'ha5a; // core off: no valid sample
      else if (route.bandgap_route)
         sample_data = route.bandgap_on ? BG_LEVEL : 12'h000;
      else
         sample_data = {route.channel, 8'h3c} ^ {8'h00, route.channel};
   end
endmodule // acr_analog_model
`default_nettype wire

// [sim/test_adc_control_register_block.sv]
// test_adc_control_register_block: register, routing and conversion tests.
// assumes zero-wait apb slave and the analog model as the far side.
`timescale 1ns/100ps
`default_nettype none
module test_adc_control_register_block;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, lvm, erf;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [11:0] sample_data;
   acr_pkg::acr_route_t route;
   logic converter_reset, conv_tick, conv_done, ref_dis;
   logic [9:0] pullup_disable;
   int n_fail, n_tests;
   localparam int BG_SETTLE_CYCLES = 20; // arbitrary bandgap settle wait
   acr_control dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_data(sample_data),
      .low_voltage_monitor(lvm), .route(route), .converter_reset(converter_reset),
      .conv_tick(conv_tick), .conv_done(conv_done), .pullup_disable(pullup_disable),
      .ref_pin_shared_disable(ref_dis));
   acr_analog_model model_u (.route(route), .sample_data(sample_data));
   // 25 mhz clock
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic test_done();
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      erf = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // let the write land before the caller looks at outputs
      @(negedge pclk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // launch one conversion and judge tick spacing and result layout
   task automatic convert(input logic [7:0] r, input logic al, input logic [3:0] ch,
      input logic [11:0] s);
      int c, first, last, nt;
      apb(1'b1, acr_pkg::OFF_REF_CLOCK, {24'h0, r});
      apb(1'b1, acr_pkg::OFF_START_CHAN, {24'h0, 3'b100, al, ch});
      chk(converter_reset, 1'b1);
      rdc(acr_pkg::OFF_START_CHAN, {24'h0, 3'b110, al, ch});
      apb(1'b1, acr_pkg::OFF_START_CHAN, {24'h0, 3'b000, al, ch});
      c = 0;
      nt = 0;
      first = 0;
      last = 0;
      // sampled mid-cycle; the first tick may already stand on entry
      while (conv_done !== 1'b1 && c < 5000)
      begin
         if (conv_tick === 1'b1)
         begin
            if (nt == 0)
               first = c;
            last = c;
            nt++;
         end
         @(negedge pclk);
         c++;
      end
      chk(conv_done, 1'b1);
      chk(nt, 16);
      chk(last - first, 15 << r[2:0]);
      rdc(acr_pkg::OFF_RESULT_HIGH, al ? {28'h0, s[11:8]} : {24'h0, s[11:4]});
      rdc(acr_pkg::OFF_RESULT_LOW, al ? {24'h0, s[7:0]} : {24'h0, s[3:0], 4'h0});
      rdc(acr_pkg::OFF_START_CHAN, {24'h0, 3'b000, al, ch});
   endtask
   initial
   begin
      #(20000 * 40);
      n_fail++;
      test_done();
   end
   initial
   begin
      logic [3:0] q;
      n_fail = 0;
      n_tests = 0;
      {presetn, clk_en, psel, penable, pwrite, lvm} = 6'b010000;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      // reset values and an unmapped access
      rdc(acr_pkg::OFF_START_CHAN, 32'h60);
      chk(route.powered, 1'b0);
      rdc(acr_pkg::OFF_REF_CLOCK, 32'h0);
      rdc(acr_pkg::OFF_PIN_EN_HIGH, 32'h0);
      rdc(8'h18, 32'h0);
      chk(erf, 1'b1);
      // reserved reference bits, external reference, bandgap route
      apb(1'b1, acr_pkg::OFF_REF_CLOCK, 32'hff);
      chk(erf, 1'b0);
      rdc(acr_pkg::OFF_REF_CLOCK, 32'hd7);
      chk({route.ext_ref, ref_dis, route.bandgap_route}, 3'b111);
      apb(1'b1, acr_pkg::OFF_REF_CLOCK, 32'h0);
      chk(route.bandgap_on, 1'b0);
      @(posedge pclk);
      lvm <= 1'b1;
      @(negedge pclk);
      chk(route.bandgap_on, 1'b1);
      @(posedge pclk);
      lvm <= 1'b0;
      // every channel code
      for (int i = 0; i < 16; i++)
      begin
         q = i[3:0];
         apb(1'b1, acr_pkg::OFF_START_CHAN, {28'h0, q});
         chk(route.channel, (q > 4'h8) ? 4'h9 : q);
         chk(route.powered, 1'b1);
      end
      // pin enables, upper bits of the high byte unwritable
      apb(1'b1, acr_pkg::OFF_PIN_EN_LOW, 32'ha5);
      apb(1'b1, acr_pkg::OFF_PIN_EN_HIGH, 32'hff);
      rdc(acr_pkg::OFF_PIN_EN_HIGH, 32'h03);
      chk(route.analog_pin_enables, 10'h3a5);
      chk(pullup_disable, 10'h3a5);
      // a write with the clock enable low must leave the register alone
      @(posedge pclk);
      clk_en <= 1'b0;
      apb(1'b1, acr_pkg::OFF_PIN_EN_LOW, 32'h5a);
      @(posedge pclk);
      clk_en <= 1'b1;
      rdc(acr_pkg::OFF_PIN_EN_LOW, 32'ha5);
      // every defined divider, both alignments
      for (int d = 0; d < 7; d++)
      begin
         q = 4'(2 * d + 3);
         convert(8'(d), d[0], q, {(q > 4'h8) ? 4'h9 : q, 8'h3c} ^ 12'((q > 4'h8) ? 4'h9 : q));
      end
      apb(1'b1, acr_pkg::OFF_REF_CLOCK, 32'h41);
      repeat (BG_SETTLE_CYCLES) @(posedge pclk);
      convert(8'hc1, 1'b1, 4'h2, 12'h5a3);
      // busy bit ignores writes
      apb(1'b1, acr_pkg::OFF_START_CHAN, 32'h40);
      rdc(acr_pkg::OFF_START_CHAN, 32'h00);
      // power down while idle; a start sequence then must not launch
      apb(1'b1, acr_pkg::OFF_START_CHAN, 32'h20);
      chk(route.powered, 1'b0);
      apb(1'b1, acr_pkg::OFF_START_CHAN, 32'ha0);
      apb(1'b1, acr_pkg::OFF_START_CHAN, 32'h20);
      repeat (20) @(posedge pclk);
      rdc(acr_pkg::OFF_START_CHAN, 32'h60);
      test_done();
   end
endmodule // test_adc_control_register_block
`default_nettype wire
